// File: hw/eeprom_wt.sv
// slave front end: bus filtering, conditions, page capture and commit
//
// Notes on behaviour
// - a start seen mid-byte drops the transaction back to standby
// - stop before the first data byte completes aborts, storing nothing
// - stop after whole data bytes commits those bytes, drops the partial one
// - page pointer wraps at 32 bytes; byte 33 overwrites byte one, same page
// - clock and data lines ignore pulses of 160 ns or shorter
// - address counter advances on the falling clock ending each eighth bit
// - low supply cancels the pending write when its stop arrives
`timescale 1ns/1ps
`include "eeprom_wt_cfg.svh"
module eeprom_wt
   import eeprom_wt_pkg::*;
#(
   parameter int FILT_CYC = `WT_FILT_CYC
) (
   input  wire logic      core_clk_in,
   input  wire logic      nrst_in,
   input  wire logic      link_clk_in,
   input  wire logic      scl_in,
   input  wire logic      sda_in,
   input  wire logic      low_vcc_in,
   output logic           prog_start_out,
   output logic           prog_busy_out,
   output prog_req_s      prog_req_out
);

   // the filter counter is eight bits wide, so the window must fit it
   generate
      if (FILT_CYC < 1 || FILT_CYC > 250) begin : g_bad_filt
         $error("FILT_CYC out of range");
      end
   endgenerate

   // ---------------- link domain ----------------
   logic        rst_l_meta;
   logic        rst_l_n;
   bus_lines_s  pin_meta;
   bus_lines_s  pin_sync;
   logic        lv_meta;
   logic        lv_sync;
   bus_lines_s  filt;
   bus_lines_s  filt_q;
   logic [`WT_CNT_W-1:0] flt_cnt [2];
   wire  [1:0]  pin_vec  = {pin_sync.scl, pin_sync.sda};
   wire  [1:0]  filt_vec = {filt.scl, filt.sda};
   logic [1:0]  next_filt_vec;

   // reset reaches the link domain through its own two-stage sync
   always_ff @(posedge link_clk_in) begin
      rst_l_meta <= nrst_in;
      rst_l_n    <= rst_l_meta;
   end

   always_ff @(posedge link_clk_in) begin
      pin_meta <= '{scl: scl_in, sda: sda_in};
      pin_sync <= pin_meta;
      lv_meta  <= low_vcc_in;
      lv_sync  <= lv_meta;
   end

   // a change is accepted only after it has held longer than the window
   localparam logic [`WT_CNT_W-1:0] FILT_LIM = FILT_CYC[`WT_CNT_W-1:0];
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_filt
         wire differs = pin_vec[g] != filt_vec[g];
         always_ff @(posedge link_clk_in) begin
            if (!rst_l_n || !differs) begin
               flt_cnt[g] <= '0;
            end else if (flt_cnt[g] != FILT_LIM) begin
               flt_cnt[g] <= flt_cnt[g] + 1'b1;
            end else begin
               flt_cnt[g] <= '0;
            end
         end
         assign next_filt_vec[g] = (differs && flt_cnt[g] == FILT_LIM) ?
                                   pin_vec[g] : filt_vec[g];
      end
   endgenerate

   always_ff @(posedge link_clk_in) begin
      if (!rst_l_n) begin
         filt   <= '{scl: 1'b1, sda: 1'b1};
         filt_q <= '{scl: 1'b1, sda: 1'b1};
      end else begin
         filt   <= '{scl: next_filt_vec[1], sda: next_filt_vec[0]};
         filt_q <= filt;
      end
   end

   wire scl_rise = filt.scl && !filt_q.scl;
   wire scl_fall = !filt.scl && filt_q.scl;
   wire start_c  = filt.scl && filt_q.scl && !filt.sda && filt_q.sda;
   wire stop_c   = filt.scl && filt_q.scl && filt.sda && !filt_q.sda;

   link_state_e                 state;
   link_state_e                 next_state;
   logic [3:0]                  bit_cnt;
   logic [7:0]                  shreg;
   logic [`WT_ADDR_W-9:0]       addr_hi;
   logic [`WT_PAGE_W-1:0]       page;
   logic [`WT_PTR_W-1:0]        ptr;
   logic [7:0]                  page_buf [`WT_PAGE_BYTES];
   logic [`WT_PAGE_BYTES-1:0]   mask;
   logic                        have_byte;
   logic                        commit_tgl;
   logic                        ack_meta;
   logic                        ack_sync;
   logic                        ack_tgl;

   wire byte_done = scl_fall && bit_cnt == `WT_BIT_LAST;
   wire mid_byte  = bit_cnt != 4'h0 && bit_cnt != `WT_BIT_ACK;
   // a commit stays pending until the core side copies the page
   wire pending   = commit_tgl != ack_sync;
   wire commit_ok = stop_c && state == ST_DATA && have_byte && !lv_sync &&
                    !pending;
   wire data_wr   = byte_done && state == ST_DATA;
   wire hi_wr     = byte_done && state == ST_ADDR_HI;
   wire lo_wr     = byte_done && state == ST_ADDR_LO;
   wire [`WT_PAGE_W-1:0] page_of = {addr_hi, shreg[7:`WT_PTR_W]};

   always_comb begin
      next_state = state;
      if (stop_c) begin
         next_state = ST_IDLE;
      end else if (start_c) begin
         // a start inside a byte or with a commit pending is an error; otherwise at a boundary it opens anew
         next_state = (mid_byte || pending) ? ST_IDLE : ST_CTRL;
      end else if (byte_done) begin
         case (state)
            ST_CTRL:    next_state = shreg[0] ? ST_IGNORE : ST_ADDR_HI;
            ST_ADDR_HI: next_state = ST_ADDR_LO;
            ST_ADDR_LO: next_state = ST_DATA;
            ST_DATA:    next_state = ST_DATA;
            ST_IGNORE:  next_state = ST_IGNORE;
            ST_IDLE:    next_state = ST_IDLE;
            default:    next_state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (!rst_l_n) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (!rst_l_n || start_c || stop_c) begin
         bit_cnt <= 4'h0;
      end else if (scl_rise) begin
         bit_cnt <= bit_cnt + 4'h1;
      end else if (scl_fall && bit_cnt == `WT_BIT_ACK) begin
         bit_cnt <= 4'h0;
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (!rst_l_n) begin
         shreg <= 8'h00;
      end else if (scl_rise && bit_cnt < `WT_BIT_LAST) begin
         shreg <= {shreg[6:0], filt.sda};
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (!rst_l_n) begin
         addr_hi <= '0;
      end else if (hi_wr) begin
         addr_hi <= shreg[`WT_ADDR_W-9:0];
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (!rst_l_n) begin
         page <= '0;
      end else if (lo_wr) begin
         page <= page_of;
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (!rst_l_n) begin
         ptr <= '0;
      end else if (lo_wr) begin
         ptr <= shreg[`WT_PTR_W-1:0];
      end else if (data_wr) begin
         // the pointer is only page-offset wide, so it wraps in place
         ptr <= ptr + 1'b1;
      end
   end

   // bytes land only once all eight bits are in; a partial byte never does
   // slots start cleared so a copy never carries unknown bytes
   generate
      for (g = 0; g < `WT_PAGE_BYTES; g++) begin : g_slot
         localparam int unsigned SLOT = g;
         wire slot_wr = data_wr && ptr == SLOT[`WT_PTR_W-1:0];
         always_ff @(posedge link_clk_in) begin
            if (!rst_l_n) begin
               page_buf[g] <= 8'h00;
            end else if (slot_wr) begin
               page_buf[g] <= shreg;
            end
         end
      end
   endgenerate

   always_ff @(posedge link_clk_in) begin
      if (!rst_l_n || lo_wr) begin
         mask <= '0;
      end else if (data_wr) begin
         mask[ptr] <= 1'b1;
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (!rst_l_n || lo_wr) begin
         have_byte <= 1'b0;
      end else if (data_wr) begin
         have_byte <= 1'b1;
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (!rst_l_n) begin
         commit_tgl <= 1'b0;
      end else if (commit_ok) begin
         commit_tgl <= ~commit_tgl;
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (!rst_l_n) begin
         ack_meta <= 1'b0;
         ack_sync <= 1'b0;
      end else begin
         ack_meta <= ack_tgl;
         ack_sync <= ack_meta;
      end
   end

   // ---------------- core domain ----------------
   logic        copy_now;
   logic        cmt_meta;
   logic        cmt_sync;
   logic        cmt_seen;
   wire         cmt_edge = cmt_sync != cmt_seen;
   wire  [`WT_PAGE_BYTES*8-1:0] buf_flat;

   generate
      for (g = 0; g < `WT_PAGE_BYTES; g++) begin : g_flat
         assign buf_flat[g*8 +: 8] = page_buf[g];
      end
   endgenerate

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         cmt_meta <= 1'b0;
         cmt_sync <= 1'b0;
         cmt_seen <= 1'b0;
      end else begin
         cmt_meta <= commit_tgl;
         cmt_sync <= cmt_meta;
         cmt_seen <= cmt_sync;
      end
   end

   // one cycle of slack lets busy rise before the start pulse
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         copy_now <= 1'b0;
      end else begin
         copy_now <= cmt_edge;
      end
   end

   // link side holds page, mask and bytes still until this copy is acked
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         prog_req_out   <= '0;
         prog_start_out <= 1'b0;
         ack_tgl        <= 1'b0;
      end else begin
         prog_start_out <= copy_now;
         if (copy_now) begin
            prog_req_out <= '{page: page, mask: mask, data: buf_flat};
            ack_tgl      <= ~ack_tgl;
         end
      end
   end

   // busy while a commit is in flight between the two domains
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         prog_busy_out <= 1'b0;
      end else begin
         prog_busy_out <= cmt_sync != ack_tgl;
      end
   end

endmodule // eeprom_wt

// File: hw/eeprom_wt_cfg.svh
// constants for the serial eeprom write-termination front end
`ifndef EEPROM_WT_CFG_SVH
`define EEPROM_WT_CFG_SVH
`define WT_PAGE_BYTES   32
`define WT_PTR_W        5
`define WT_ADDR_W       13
`define WT_PAGE_W       8
`define WT_FILT_NS      160
`define WT_LINK_PS      6000
`define WT_FILT_CYC     (((`WT_FILT_NS * 1000) + `WT_LINK_PS - 1) / `WT_LINK_PS)
`define WT_BIT_LAST     4'h8
`define WT_BIT_ACK      4'h9
`define WT_CNT_W        8
`endif

// File: hw/eeprom_wt_pkg.sv
// types for the serial eeprom write-termination front end
`include "eeprom_wt_cfg.svh"
package eeprom_wt_pkg;
   typedef enum logic [5:0] {
      ST_IDLE    = 6'h01,
      ST_CTRL    = 6'h02,
      ST_ADDR_HI = 6'h04,
      ST_ADDR_LO = 6'h08,
      ST_DATA    = 6'h10,
      ST_IGNORE  = 6'h20
   } link_state_e;

   typedef struct packed {
      logic [`WT_PAGE_W-1:0]         page;
      logic [`WT_PAGE_BYTES-1:0]     mask;
      logic [`WT_PAGE_BYTES*8-1:0]   data;
   } prog_req_s;

   typedef struct packed {
      logic scl;
      logic sda;
   } bus_lines_s;
endpackage

// File: sim/bus_ctrl_model.sv
// two-wire bus controller model driving clock and data
`timescale 1ns/1ps
module bus_ctrl_model (
   input  wire logic clk_in,
   output logic      scl_out,
   output logic      sda_out
);
   // both lines idle high through their pull-ups
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // 300 ns phases keep data changes clear of the clock edges
   task automatic ph();
      repeat (12) @(negedge clk_in);
   endtask
   task automatic start();
      sda_out = 1'b1;
      ph();
      scl_out = 1'b1;
      ph();
      sda_out = 1'b0;
      ph();
      scl_out = 1'b0;
      ph();
   endtask
   task automatic stop();
      sda_out = 1'b0;
      ph();
      scl_out = 1'b1;
      ph();
      sda_out = 1'b1;
      ph();
   endtask
   task automatic clk_bit(input logic v);
      sda_out = v;
      ph();
      scl_out = 1'b1;
      ph();
      scl_out = 1'b0;
      ph();
   endtask
   // top n bits msb first; a whole byte gets its ack clock, sda released
   task automatic send(input logic [7:0] b, input int n);
      for (int i = 7; i > 7 - n; i--) clk_bit(b[i]);
      if (n == 8) clk_bit(1'b1);
   endtask
   // 150 ns clock pulse, short enough that it must be ignored
   task automatic glitch();
      scl_out = 1'b1;
      repeat (6) @(negedge clk_in);
      scl_out = 1'b0;
      ph();
   endtask
endmodule // bus_ctrl_model

// File: sim/eeprom_wt_chk.sv
// port assertions for the write-termination front end
`timescale 1ns/1ps
module eeprom_wt_chk
   import eeprom_wt_pkg::*;
#(
   parameter int FILT_CYC = 27
) (
   input wire logic      core_clk_in,
   input wire logic      nrst_in,
   input wire logic      link_clk_in,
   input wire logic      scl_in,
   input wire logic      sda_in,
   input wire logic      low_vcc_in,
   input wire logic      prog_start_out,
   input wire logic      prog_busy_out,
   input wire prog_req_s prog_req_out
);
   // filter plus crossing latency, with slack for sync phase
   localparam int QB = FILT_CYC / 4 + 16;
   logic [7:0] quiet;
   logic       scl_q;
   logic       sda_q;
   always_ff @(posedge core_clk_in) begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (!nrst_in) quiet <= 8'hFF;
      else if (scl_q != scl_in || sda_q != sda_in) quiet <= 8'h00;
      else if (quiet != 8'hFF) quiet <= quiet + 8'h01;
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   AST_START_ONE_CYCLE: assert property (
      prog_start_out |=> !prog_start_out) else $error("start not a pulse");
   AST_REQ_HOLDS: assert property (
      !prog_start_out |-> $stable(prog_req_out)) else $error("req moved");
   AST_MASK_WHOLE: assert property (
      prog_start_out |-> prog_req_out.mask != 32'h0) else $error("no bytes");
   AST_LOW_SUPPLY: assert property (
      low_vcc_in [*8] |-> !prog_start_out) else $error("low supply write");
   AST_BUSY_LEADS: assert property (
      $rose(prog_start_out) |-> $past(prog_busy_out)) else $error("no busy");
   AST_BUSY_ENDS: assert property (
      $rose(prog_busy_out) |-> ##[1:30] !prog_busy_out)
      else $error("busy stuck");
   AST_IDLE_AT_COMMIT: assert property (
      prog_start_out |-> scl_in && sda_in) else $error("commit, bus busy");
   AST_RECENT_STOP: assert property (
      prog_start_out |-> quiet <= QB) else $error("commit without stop");
endmodule // eeprom_wt_chk
bind eeprom_wt eeprom_wt_chk #(.FILT_CYC(FILT_CYC)) chk (
   .core_clk_in, .nrst_in, .link_clk_in, .scl_in, .sda_in, .low_vcc_in,
   .prog_start_out, .prog_busy_out, .prog_req_out
);

// File: sim/serial_eeprom_write_termination_test.sv
// self-checking bench for the write-termination front end
`timescale 1ns/1ps
module serial_eeprom_write_termination_test;
   import eeprom_wt_pkg::*;
   logic         clk, lclk, nrst, low, scl, sda, start, busy;
   prog_req_s    req;
   int           fails, checks_done, n_start;
   logic [255:0] ed;
   logic [31:0]  em;
   eeprom_wt dut (.core_clk_in(clk), .nrst_in(nrst), .link_clk_in(lclk),
      .scl_in(scl), .sda_in(sda), .low_vcc_in(low),
      .prog_start_out(start), .prog_busy_out(busy), .prog_req_out(req));
   bus_ctrl_model bus (.clk_in(clk), .scl_out(scl), .sda_out(sda));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      lclk = 1'b0;
      #1.7;
      forever #3 lclk = ~lclk;
   end
   // pulses are counted as they pass, however early after the stop
   always @(negedge clk) begin
      if (start === 1'b1) n_start++;
   end
   task automatic summarize();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input bit ok, input string m);
      checks_done++;
      if (!ok) begin
         fails++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   // unwritten slots carry no promise, so only masked bytes compare
   function automatic logic [255:0] keep(logic [255:0] d, logic [31:0] m);
      for (int k = 0; k < 32; k++) if (!m[k]) d[k*8 +: 8] = 8'h00;
      return d;
   endfunction
   task automatic wait_commit(input bit ex, input logic [7:0] pg,
                              input int s0);
      bit seen;
      repeat (300) @(negedge clk);
      seen = (n_start - s0) == 1;
      chk((n_start - s0) == (ex ? 1 : 0), "commit");
      if (ex && seen) begin
         chk(req.page === pg, "page");
         chk(req.mask === em, "mask");
         chk(keep(req.data, em) === ed, "data");
      end
      if (ex && !seen) summarize();
   endtask
   task automatic xfer(int n, int part, bit gl, bit rs, bit lv, bit ex);
      logic [7:0] pg, b;
      logic [4:0] p;
      int         s0;
      s0 = n_start;
      pg = 8'($urandom);
      p = 5'($urandom);
      ed = '0;
      em = '0;
      low = lv;
      bus.start();
      bus.send(8'hA0, 8);
      bus.send({3'h0, pg[7:3]}, 8);
      bus.send({pg[2:0], p}, 8);
      repeat (n) begin
         b = 8'($urandom);
         if (gl) bus.glitch();
         bus.send(b, 8);
         ed[p*8 +: 8] = b;
         em[p] = 1'b1;
         p++;
      end
      bus.send(8'($urandom), part);
      if (rs) begin
         // after the stray start a whole write must fall on deaf ears
         bus.start();
         bus.send(8'hA0, 8);
         bus.send({3'h0, pg[7:3]}, 8);
         bus.send({pg[2:0], p}, 8);
         bus.send(8'($urandom), 8);
      end
      bus.stop();
      wait_commit(ex, pg, s0);
      low = 1'b0;
      $display("test done: %0d bytes", n);
   endtask
   initial begin
      nrst = 1'b0;
      low = 1'b0;
      void'($urandom(32'hF210));
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      xfer(1, 0, 0, 0, 0, 1);
      xfer($urandom_range(4, 2), 5, 0, 0, 0, 1);
      xfer(0, 5, 0, 0, 0, 0);
      xfer(34, 0, 0, 0, 0, 1);
      xfer(2, 4, 0, 1, 0, 0);
      xfer(2, 0, 0, 0, 1, 0);
      xfer(3, 3, 1, 0, 0, 1);
      summarize();
   end
   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      summarize();
   end
endmodule // serial_eeprom_write_termination_test
